/* src/lmrs_pkg.sv */
// Purpose: Shared constants and types of the run/stop and I/O scan controller.
// Assumes: One clock, synchronous active-high reset.
// Notes: Connector codes form one 6-bit namespace used by the stored program.
package lmrs_pkg;
    // ------------------------------------------------------------------
    // Sizes of the connector namespace
    // ------------------------------------------------------------------
    localparam int LMRS_NUM_DIN = 24;
    localparam int LMRS_NUM_AIN = 8;
    localparam int LMRS_NUM_Q = 16;
    localparam int LMRS_NUM_M = 8;
    localparam int LMRS_NUM_COIL = LMRS_NUM_Q + LMRS_NUM_M;
    localparam int LMRS_NUM_BASE_Q = 4;
    localparam int LMRS_SRC_PER_BLK = 3;
    localparam int LMRS_CODE_W = 6;
    localparam int LMRS_AIN_W = 10;
    localparam int LMRS_PROG_W = LMRS_NUM_COIL * LMRS_SRC_PER_BLK * LMRS_CODE_W;
    // ------------------------------------------------------------------
    // Connector codes
    // ------------------------------------------------------------------
    localparam logic [5:0] LMRS_CON_LO = 6'h00;
    localparam logic [5:0] LMRS_CON_HI = 6'h01;
    localparam logic [5:0] LMRS_CON_X = 6'h02;
    localparam logic [5:0] LMRS_CON_I_BASE = 6'h08;
    localparam logic [5:0] LMRS_CON_AI_BASE = 6'h20;
    localparam logic [5:0] LMRS_CON_COIL_BASE = 6'h28;
    // Raw analog reading at or above which an analog connector reads as 1.
    localparam logic [9:0] LMRS_AI_ON_LVL = 10'h200;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [23:0] LMRS_COIL_RST = 24'h000000;
    localparam logic [23:0] LMRS_DIN_RST = 24'h000000;
    localparam logic [15:0] LMRS_Q_RST = 16'h0000;
    // ------------------------------------------------------------------
    // Operating states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        LMRS_ST_INIT = 4'h0,
        LMRS_ST_ERASE = 4'h1,
        LMRS_ST_COPY = 4'h2,
        LMRS_ST_DECIDE = 4'h3,
        LMRS_ST_NOPROG = 4'h4,
        LMRS_ST_STOP = 4'h5,
        LMRS_ST_SAMPLE = 4'h6,
        LMRS_ST_EVAL = 4'h7,
        LMRS_ST_OUTPUT = 4'h8
    } lmrs_state_t;
endpackage : lmrs_pkg

/* src/lmrs_top.sv */
// Purpose: Power-up decision, STOP/RUN control and cyclic I/O scan of a logic module.
// Assumes: Program storage, memory module and menu logic sit on ref_clk; pins do not.
// Notes: One scan is three states: sample, evaluate, drive outputs.
`timescale 1ns/1ps
module lmrs_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Power-up conditions
    input wire logic has_display,
    input wire logic int_prog_valid,
    input wire logic card_prog_valid,
    input wire logic last_state_run,
    input wire logic edit_interrupted,
    input wire logic retentive_en,
    input wire logic [23:0] retained_coils,
    // Storage handshakes
    output logic copy_req,
    input wire logic copy_done,
    output logic erase_req,
    input wire logic erase_done,
    input wire logic prog_saved,
    // Operator
    input wire logic esc_key,
    input wire logic start_cmd,
    input wire logic stop_cmd,
    // Program image
    input wire logic [lmrs_pkg::LMRS_PROG_W-1:0] prog_src,
    input wire logic [lmrs_pkg::LMRS_NUM_COIL-1:0] prog_and,
    // Field inputs, base first then expansion modules in module order
    input wire logic [lmrs_pkg::LMRS_NUM_DIN-1:0] din_pin,
    input wire logic [lmrs_pkg::LMRS_NUM_AIN*lmrs_pkg::LMRS_AIN_W-1:0] ain_val,
    // Outputs and status
    output logic [lmrs_pkg::LMRS_NUM_BASE_Q-1:0] base_q,
    output logic [lmrs_pkg::LMRS_NUM_Q-1:0] exp_q,
    output logic [23:0] retain_coils,
    output logic run_state,
    output logic no_prog_msg,
    output logic lamp_red,
    output logic lamp_green
);
    import lmrs_pkg::*;

    lmrs_state_t state_ff;
    lmrs_state_t nxt_state;
    logic disp_ff;
    logic prog_ff;
    logic [2:0] esc_sync_ff;
    logic esc_stable_ff;
    logic esc_press;
    logic [23:0] din_s1_ff;
    logic [23:0] din_s2_ff;
    logic [23:0] din_s3_ff;
    logic [23:0] din_stable_ff;
    logic [23:0] in_img_ff;
    logic [7:0] ai_img_ff;
    logic [23:0] coil_ff;
    logic [23:0] nxt_coil;
    logic [15:0] q_ff;
    logic in_run;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // input level filter
    // A level is taken only when the second and third stages agree.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            din_s1_ff <= LMRS_DIN_RST;
            din_s2_ff <= LMRS_DIN_RST;
            din_s3_ff <= LMRS_DIN_RST;
            din_stable_ff <= LMRS_DIN_RST;
        end else begin
            din_s1_ff <= din_pin;
            din_s2_ff <= din_s1_ff;
            din_s3_ff <= din_s2_ff;
            for (int i = 0; i < LMRS_NUM_DIN; i++) begin
                if (din_s2_ff[i] == din_s3_ff[i]) begin
                    din_stable_ff[i] <= din_s3_ff[i];
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            esc_sync_ff <= 3'h0;
            esc_stable_ff <= 1'b0;
        end else begin
            esc_sync_ff <= {esc_sync_ff[1:0], esc_key};
            if (esc_sync_ff[1] == esc_sync_ff[2]) begin
                esc_stable_ff <= esc_sync_ff[2];
            end
        end
    end

    assign esc_press = esc_sync_ff[1] && esc_sync_ff[2] && !esc_stable_ff;

    // ------------------------------------------------------------------
    // Connector evaluation
    // ------------------------------------------------------------------
    function automatic logic conn_val(input logic [5:0] code, input logic [23:0] din,
                                      input logic [7:0] ai, input logic [23:0] coil,
                                      input logic and_op);
        logic v;
        v = 1'b0;
        if (code == LMRS_CON_LO) begin
            v = 1'b0;
        end else if (code == LMRS_CON_HI) begin
            v = 1'b1;
        end else if (code == LMRS_CON_X) begin
            v = and_op;
        end else if (code >= LMRS_CON_I_BASE && code < LMRS_CON_AI_BASE) begin
            v = din[5'(code - LMRS_CON_I_BASE)];
        end else if (code >= LMRS_CON_AI_BASE && code < LMRS_CON_COIL_BASE) begin
            v = ai[3'(code - LMRS_CON_AI_BASE)];
        end else if (code >= LMRS_CON_COIL_BASE) begin
            v = coil[5'(code - LMRS_CON_COIL_BASE)];
        end
        return v;
    endfunction : conn_val

    // output computation
    // Feedback through outputs and memory bits uses last scan's values.
    always_comb begin
        logic acc;
        logic [5:0] code;
        acc = 1'b0;
        code = LMRS_CON_LO;
        for (int k = 0; k < LMRS_NUM_COIL; k++) begin
            acc = prog_and[k];
            for (int j = 0; j < LMRS_SRC_PER_BLK; j++) begin
                code = prog_src[(k*LMRS_SRC_PER_BLK+j)*LMRS_CODE_W +: LMRS_CODE_W];
                if (prog_and[k]) begin
                    acc = acc & conn_val(code, in_img_ff, ai_img_ff, coil_ff, 1'b1);
                end else begin
                    acc = acc | conn_val(code, in_img_ff, ai_img_ff, coil_ff, 1'b0);
                end
            end
            nxt_coil[k] = acc;
        end
    end

    // ------------------------------------------------------------------
    // Operating state machine
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LMRS_ST_INIT: begin
                if (edit_interrupted) begin
                    nxt_state = LMRS_ST_ERASE;
                end else if (card_prog_valid) begin
                    nxt_state = LMRS_ST_COPY;
                end else begin
                    nxt_state = LMRS_ST_DECIDE;
                end
            end
            LMRS_ST_ERASE: begin
                if (erase_done) begin
                    nxt_state = LMRS_ST_DECIDE;
                end
            end
            LMRS_ST_COPY: begin
                if (copy_done) begin
                    nxt_state = LMRS_ST_DECIDE;
                end
            end
            LMRS_ST_DECIDE: begin
                if (!prog_ff) begin
                    nxt_state = disp_ff ? LMRS_ST_NOPROG : LMRS_ST_STOP;
                end else if (!disp_ff || last_state_run) begin
                    nxt_state = LMRS_ST_SAMPLE;
                end else begin
                    nxt_state = LMRS_ST_STOP;
                end
            end
            LMRS_ST_NOPROG: begin
                if (esc_press) begin
                    nxt_state = LMRS_ST_STOP;
                end
            end
            LMRS_ST_STOP: begin
                if (start_cmd && prog_ff) begin
                    nxt_state = LMRS_ST_SAMPLE;
                end
            end
            LMRS_ST_SAMPLE: nxt_state = stop_cmd ? LMRS_ST_STOP : LMRS_ST_EVAL;
            LMRS_ST_EVAL: nxt_state = LMRS_ST_OUTPUT;
            LMRS_ST_OUTPUT: nxt_state = stop_cmd ? LMRS_ST_STOP : LMRS_ST_SAMPLE;
            default: nxt_state = LMRS_ST_INIT;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff <= LMRS_ST_INIT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign in_run = (state_ff == LMRS_ST_SAMPLE) || (state_ff == LMRS_ST_EVAL) ||
                    (state_ff == LMRS_ST_OUTPUT);

    // Display and program presence are caught in the first cycle after reset; program presence is set again by copy_done in COPY or prog_saved in STOP.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            disp_ff <= 1'b1;
            prog_ff <= 1'b0;
        end else begin
            if (state_ff == LMRS_ST_INIT) begin
                disp_ff <= has_display;
                prog_ff <= int_prog_valid && !edit_interrupted;
            end else if (state_ff == LMRS_ST_COPY && copy_done) begin
                prog_ff <= 1'b1;
            end else if (state_ff == LMRS_ST_STOP && prog_saved) begin
                prog_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            copy_req <= 1'b0;
            erase_req <= 1'b0;
        end else begin
            copy_req <= (nxt_state == LMRS_ST_COPY);
            erase_req <= (nxt_state == LMRS_ST_ERASE);
        end
    end

    // ------------------------------------------------------------------
    // Scan datapath
    // ------------------------------------------------------------------
    // inputs read only in sample phase
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            in_img_ff <= LMRS_DIN_RST;
            ai_img_ff <= 8'h00;
        end else if (state_ff == LMRS_ST_SAMPLE) begin
            in_img_ff <= din_stable_ff;
            for (int a = 0; a < LMRS_NUM_AIN; a++) begin
                ai_img_ff[a] <= ain_val[a*LMRS_AIN_W +: LMRS_AIN_W] >= LMRS_AI_ON_LVL;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            coil_ff <= LMRS_COIL_RST;
        end else if (state_ff == LMRS_ST_DECIDE) begin
            coil_ff <= retentive_en ? retained_coils : LMRS_COIL_RST;
        end else if (state_ff == LMRS_ST_EVAL) begin
            coil_ff <= nxt_coil;
        end
    end

    // retained image
    // Copy of the last complete scan is what nonvolatile storage keeps.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            retain_coils <= LMRS_COIL_RST;
        end else if (state_ff == LMRS_ST_OUTPUT) begin
            retain_coils <= coil_ff;
        end
    end

    // output drive
    // Outputs drop on the edge that enters STOP, so no STOP cycle drives a load.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q_ff <= LMRS_Q_RST;
        end else if (!in_run || nxt_state == LMRS_ST_STOP) begin
            q_ff <= LMRS_Q_RST;
        end else if (state_ff == LMRS_ST_OUTPUT) begin
            q_ff <= coil_ff[LMRS_NUM_Q-1:0];
        end
    end

    assign base_q = q_ff[LMRS_NUM_BASE_Q-1:0];
    assign exp_q = {q_ff[LMRS_NUM_Q-1:LMRS_NUM_BASE_Q], {LMRS_NUM_BASE_Q{1'b0}}};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            run_state <= 1'b0;
            no_prog_msg <= 1'b0;
            lamp_red <= 1'b0;
            lamp_green <= 1'b0;
        end else begin
            if (state_ff == LMRS_ST_STOP || state_ff == LMRS_ST_NOPROG) begin
                run_state <= 1'b0;
            end else if (in_run) begin
                run_state <= 1'b1;
            end
            no_prog_msg <= (nxt_state == LMRS_ST_NOPROG) && disp_ff;
            lamp_red <= !disp_ff && (state_ff == LMRS_ST_STOP);
            lamp_green <= !disp_ff && in_run;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence scan_seq;
        state_ff == LMRS_ST_SAMPLE ##1 state_ff == LMRS_ST_EVAL ##1 state_ff == LMRS_ST_OUTPUT;
    endsequence

    stop_outputs_off_a: assert property (
        state_ff == LMRS_ST_STOP |-> q_ff == LMRS_Q_RST)
        else $error("Outputs not off in STOP.");

    stop_no_sample_a: assert property (
        state_ff == LMRS_ST_STOP |=> $stable(in_img_ff))
        else $error("Input image changed in STOP.");

    scan_order_a: assert property (
        state_ff == LMRS_ST_SAMPLE && !stop_cmd |-> scan_seq)
        else $error("Scan phases out of order.");

    out_follows_eval_a: assert property (
        state_ff == LMRS_ST_OUTPUT && !stop_cmd |=> q_ff == $past(coil_ff[15:0]))
        else $error("Outputs do not follow evaluation.");

    noprog_msg_a: assert property (
        state_ff == LMRS_ST_DECIDE && !prog_ff && disp_ff |=> no_prog_msg [*2])
        else $error("No-program message missing.");

    copy_sets_prog_a: assert property (
        state_ff == LMRS_ST_COPY && copy_done |=> prog_ff && state_ff == LMRS_ST_DECIDE)
        else $error("Copied program not taken over.");

    resume_run_a: assert property (
        state_ff == LMRS_ST_DECIDE && prog_ff && last_state_run |=> ##1 run_state)
        else $error("Previous RUN state not resumed.");

    lamp_color_a: assert property (
        !disp_ff && state_ff == LMRS_ST_STOP ##1 state_ff == LMRS_ST_STOP
        |-> lamp_red && !lamp_green)
        else $error("Lamp not red in STOP.");

    erase_clears_a: assert property (
        state_ff == LMRS_ST_ERASE && erase_done |=> !prog_ff ##1 state_ff != LMRS_ST_SAMPLE)
        else $error("Interrupted program not discarded.");

    restore_a: assert property (
        state_ff == LMRS_ST_DECIDE && retentive_en |=> coil_ff == $past(retained_coils))
        else $error("Retained values not restored.");
endmodule : lmrs_top

/* bench/lmrs_exp_model.sv */
// Purpose: Behavioural expansion modules on the far side of the scan controller.
// Assumes: Two digital modules give I9..I24, analog channels AI3..AI8 follow.
// Notes: Levels handed in are presented one cycle later, as over a link.
`timescale 1ns/1ps
module lmrs_exp_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Levels requested by the bench
    input wire logic [15:0] din_set,
    input wire logic [59:0] ain_set,
    // Controller side
    input wire logic [15:0] exp_q,
    output logic [15:0] din_exp,
    output logic [59:0] ain_exp,
    output logic [11:0] relay_img,
    // Module lamps
    output logic lamp_green,
    output logic lamp_red,
    output logic lamp_orange
);
    logic [2:0] init_cnt_ff;
    always_ff @(posedge ref_clk) begin
        din_exp <= din_set;
        ain_exp <= ain_set;
        relay_img <= exp_q[15:4];
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            init_cnt_ff <= 3'h0;
        end else if (init_cnt_ff != 3'h7) begin
            init_cnt_ff <= init_cnt_ff + 3'h1;
        end
    end
    assign lamp_red = srst;
    assign lamp_orange = !srst && (init_cnt_ff != 3'h7);
    assign lamp_green = !srst && (init_cnt_ff == 3'h7);
endmodule : lmrs_exp_model

/* bench/lmrs_top_tb_top.sv */
// Purpose: Self-checking bench of the run/stop and scan controller.
// Assumes: Storage handshakes are answered by the bench within a few cycles.
// Notes: Notes of expected outputs are queued and compared by a monitor.
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module lmrs_top_tb_top;
    import lmrs_pkg::*;
    typedef struct {logic [49:0] mask; logic [49:0] val;} lmrs_note_t;
    logic ref_clk, srst, has_display, int_prog_valid, card_prog_valid, last_state_run;
    logic edit_interrupted, retentive_en, copy_done, erase_done, prog_saved;
    logic esc_key, start_cmd, stop_cmd;
    logic [23:0] retained_coils, din_all, prog_and;
    logic [79:0] ain_all;
    logic [LMRS_PROG_W-1:0] prog_src;
    logic copy_req, erase_req, run_state, no_prog_msg, lamp_red, lamp_green;
    logic [3:0] base_q;
    logic [15:0] exp_q, din_exp;
    logic [23:0] retain_coils;
    logic [59:0] ain_exp;
    int err_total = 0;
    int check_count = 0;
    lmrs_note_t notes[$];
    event chk_ev;
    wire logic [49:0] obs = {copy_req, erase_req, run_state, no_prog_msg, lamp_red,
        lamp_green, retain_coils, exp_q, base_q};
    lmrs_top DUT (.ref_clk(ref_clk), .srst(srst), .has_display(has_display),
        .int_prog_valid(int_prog_valid), .card_prog_valid(card_prog_valid),
        .last_state_run(last_state_run), .edit_interrupted(edit_interrupted),
        .retentive_en(retentive_en), .retained_coils(retained_coils),
        .copy_req(copy_req), .copy_done(copy_done), .erase_req(erase_req),
        .erase_done(erase_done), .prog_saved(prog_saved), .esc_key(esc_key),
        .start_cmd(start_cmd), .stop_cmd(stop_cmd), .prog_src(prog_src),
        .prog_and(prog_and), .din_pin({din_exp, din_all[7:0]}),
        .ain_val({ain_exp, ain_all[19:0]}), .base_q(base_q), .exp_q(exp_q),
        .retain_coils(retain_coils), .run_state(run_state), .no_prog_msg(no_prog_msg),
        .lamp_red(lamp_red), .lamp_green(lamp_green));
    lmrs_exp_model partner (.ref_clk(ref_clk), .srst(srst), .din_set(din_all[23:8]),
        .ain_set(ain_all[79:20]), .exp_q(exp_q), .din_exp(din_exp), .ain_exp(ain_exp),
        .relay_img(), .lamp_green(), .lamp_red(), .lamp_orange());
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish();
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // Each note takes one cycle so that the monitor never misses a trigger.
    task automatic note(input logic [49:0] m, input logic [49:0] v);
        notes.push_back('{m, v});
        ->chk_ev;
        @(negedge ref_clk);
    endtask : note
    task automatic expect_st(input logic [5:0] st);
        note({6'h3F, 44'h0}, {st, 44'h0});
    endtask : expect_st
    task automatic expect_q(input logic [23:0] c);
        note({6'h00, 44'hFFFFFFFFFFF}, {6'h00, c, c[15:4], 4'h0, c[3:0]});
    endtask : expect_q
    // Bits from the top: display, internal program, card program, last RUN,
    // interrupted entry, retention, then the copy and erase requests expected.
    task automatic power_up(input logic [7:0] cfg);
        srst = 1'b1;
        {has_display, int_prog_valid, card_prog_valid} = cfg[7:5];
        {last_state_run, edit_interrupted, retentive_en} = cfg[4:2];
        repeat (4) @(negedge ref_clk);
        srst = 1'b0;
        repeat (2) @(negedge ref_clk);
        note({2'h3, 48'h0}, {cfg[1:0], 48'h0});
        // Each done pulse follows its request and falls once the request drops.
        repeat (20) begin
            copy_done = copy_req;
            erase_done = erase_req;
            @(negedge ref_clk);
        end
        copy_done = 1'b0;
        erase_done = 1'b0;
    endtask : power_up
    // Codes 0 to 39 reach fixed, unused, undefined, input and analog sources.
    // Feedback codes stay out, since the model keeps no scan memory.
    task automatic random_io(input bit edge_ai);
        for (int k = 0; k < LMRS_NUM_COIL * 3; k++) begin
            prog_src[k*6 +: 6] = 6'($urandom_range(39, 0));
        end
        prog_and = 24'($urandom);
        din_all = 24'($urandom);
        for (int n = 0; n < 8; n++) begin
            ain_all[n*10 +: 10] = edge_ai ? (n[0] ? 10'h1FF : 10'h200) : 10'($urandom);
        end
    endtask : random_io
    function automatic logic [23:0] model_coils();
        logic [23:0] c;
        logic [2:0] s;
        logic [5:0] cd;
        for (int k = 0; k < LMRS_NUM_COIL; k++) begin
            for (int j = 0; j < 3; j++) begin
                cd = prog_src[(k*3+j)*6 +: 6];
                if (cd == LMRS_CON_HI) s[j] = 1'b1;
                else if (cd == LMRS_CON_X) s[j] = prog_and[k];
                else if (cd >= LMRS_CON_AI_BASE)
                    s[j] = ain_all[(cd - LMRS_CON_AI_BASE) * 10 +: 10] >= LMRS_AI_ON_LVL;
                else if (cd >= LMRS_CON_I_BASE) s[j] = din_all[cd - LMRS_CON_I_BASE];
                else s[j] = 1'b0;
            end
            c[k] = prog_and[k] ? &s : |s;
        end
        return c;
    endfunction : model_coils
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        forever begin
            @(chk_ev);
            `CHK(obs & notes[0].mask, notes[0].val & notes[0].mask)
            void'(notes.pop_front());
        end
    end
    initial begin
        {srst, has_display, int_prog_valid, card_prog_valid, last_state_run} = 5'h10;
        {edit_interrupted, retentive_en, copy_done, erase_done, prog_saved} = 5'h00;
        {esc_key, start_cmd, stop_cmd} = 3'h0;
        {retained_coils, din_all, prog_and, ain_all, prog_src} = '0;
        void'($urandom(32'h6FF1));
        @(negedge ref_clk);
        power_up(8'h80);
        expect_st(6'h04);
        esc_key = 1'b1;
        repeat (8) @(negedge ref_clk);
        esc_key = 1'b0;
        repeat (6) @(negedge ref_clk);
        expect_st(6'h00);
        start_cmd = 1'b1;
        @(negedge ref_clk);
        start_cmd = 1'b0;
        repeat (6) @(negedge ref_clk);
        expect_st(6'h00);
        prog_saved = 1'b1;
        @(negedge ref_clk);
        prog_saved = 1'b0;
        start_cmd = 1'b1;
        @(negedge ref_clk);
        start_cmd = 1'b0;
        repeat (8) @(negedge ref_clk);
        expect_st(6'h08);
        // Inputs are held for several scans, longer than the input filter needs.
        for (int i = 0; i < 16; i++) begin
            random_io(i == 0);
            repeat (15) @(negedge ref_clk);
            expect_q(model_coils());
        end
        stop_cmd = 1'b1;
        repeat (3) @(negedge ref_clk);
        stop_cmd = 1'b0;
        din_all = ~din_all;
        repeat (10) @(negedge ref_clk);
        note({30'h0, 20'hFFFFF}, 50'h0);
        expect_st(6'h00);
        power_up(8'hF2);
        expect_st(6'h08);
        din_all = 24'hFFFFFF;
        power_up(8'hC0);
        note({30'h0, 20'hFFFFF}, 50'h0);
        expect_st(6'h00);
        power_up(8'h40);
        expect_st(6'h09);
        power_up(8'h00);
        expect_st(6'h02);
        power_up(8'hC9);
        expect_st(6'h04);
        // Coil 1 latches on its own previous value, so only a restore can set it.
        prog_src = '0;
        prog_and = 24'h000000;
        prog_src[5:0] = LMRS_CON_COIL_BASE;
        retained_coils = 24'h000001;
        for (int re = 1; re >= 0; re--) begin
            power_up({5'h1A, re[0], 2'h0});
            expect_q({23'h000000, re[0]});
        end
        tally_and_finish();
    end
endmodule : lmrs_top_tb_top
